// [rtl/prbsg_top.v]
// Pseudo-random bit sequence generator with pattern trigger
`timescale 1ns/100ps
`include "prbsg_defines.vh"
module prbsg_top
(
	clk,
	rst_n,
	pattern_reset_pin,
	length_sel_pin,
	data_p,
	data_n,
	pattern_trigger,
	data_valid,
	data_ready
);
input wire clk;
input wire rst_n;
input wire pattern_reset_pin;
input wire [1:0] length_sel_pin;
output reg data_p;
output reg data_n;
output reg pattern_trigger;
output wire data_valid;
input wire data_ready;

// ****************************************************************
// Pin synchronisers
// ****************************************************************
reg rst_meta;
reg rst_sync;
reg [1:0] sel_meta;
reg [1:0] sel_sync;
reg [1:0] sel_cur;

// Two flip-flops on the pattern reset and length select pins before use
always @(posedge clk)
begin
	if (!rst_n)
	begin
		rst_meta <= 1'b0;
		rst_sync <= 1'b0;
		sel_meta <= `PRBSG_SEL_P7;
		sel_sync <= `PRBSG_SEL_P7;
	end
	else
	begin
		rst_meta <= pattern_reset_pin;
		rst_sync <= rst_meta;
		sel_meta <= length_sel_pin;
		sel_sync <= sel_meta;
	end
end

// ****************************************************************
// Shift register
// ****************************************************************
reg [30:0] lfsr;
reg [30:0] next_lfsr;
reg [30:0] start_val;
reg feedback;
reg out_bit;
reg at_start;
wire restart;
wire step;
wire fifo_in_ready;

// A length change restarts too, but seeds the start word of the old length
assign restart = rst_sync || (sel_sync != sel_cur);
assign step = fifo_in_ready;

// Feedback and start word per length
always @*
begin
	case (sel_cur)
	`PRBSG_SEL_P7:
	begin
		feedback = lfsr[`PRBSG_P7_TAP_A] ^ lfsr[`PRBSG_P7_TAP_B]; // [RULE8]
		out_bit = lfsr[`PRBSG_P7_TAP_A];
		start_val = `PRBSG_P7_START;
	end
	`PRBSG_SEL_P15:
	begin
		feedback = lfsr[`PRBSG_P15_TAP_A] ^ lfsr[`PRBSG_P15_TAP_B]; // [RULE8]
		out_bit = lfsr[`PRBSG_P15_TAP_A];
		start_val = `PRBSG_P15_START;
	end
	`PRBSG_SEL_P31:
	begin
		feedback = lfsr[`PRBSG_P31_TAP_A] ^ lfsr[`PRBSG_P31_TAP_B]; // [RULE8]
		out_bit = lfsr[`PRBSG_P31_TAP_A];
		start_val = `PRBSG_P31_START;
	end
	default:
	begin
		// Unused code falls back to the longest length
		feedback = lfsr[`PRBSG_P31_TAP_A] ^ lfsr[`PRBSG_P31_TAP_B]; // [RULE1]
		out_bit = lfsr[`PRBSG_P31_TAP_A];
		start_val = `PRBSG_P31_START;
	end
	endcase
	// Start word doubles as the mask of the active length
	next_lfsr = {lfsr[29:0], feedback} & start_val;
	if (next_lfsr == 31'h00000000)
		next_lfsr = start_val; // [RULE10]
	at_start = (lfsr == start_val);
end

// Shift one bit per enabled clock; seed on reset or restart
always @(posedge clk)
begin
	if (!rst_n)
	begin
		lfsr <= `PRBSG_P7_START; // [RULE3] [RULE10]
		sel_cur <= `PRBSG_SEL_P7;
	end
	else if (restart)
	begin
		sel_cur <= sel_sync;
		lfsr <= start_val; // [RULE2]
	end
	else if (step)
		lfsr <= next_lfsr; // [RULE5]
end

// ****************************************************************
// Trigger timing
// ****************************************************************
reg [4:0] seq_cnt;
reg [5:0] trig_cnt;
wire trig_start;
wire trig_bit;

// Trigger travels with the bit it marks, so it is not registered
assign trig_start = at_start && (seq_cnt == 5'h00);
assign trig_bit = trig_start || (trig_cnt != 6'h00); // [RULE6]

// Counts whole sequences; raises trigger for 32 bits every 32nd
always @(posedge clk)
begin
	if (!rst_n || restart)
	begin
		seq_cnt <= 5'h00;
		trig_cnt <= 6'h00;
	end
	else if (step)
	begin
		if (trig_start)
			trig_cnt <= `PRBSG_TRIG_W - 6'h01; // [RULE6] [RULE9]
		else if (trig_cnt != 6'h00)
			trig_cnt <= trig_cnt - 6'h01;
		if (at_start)
			seq_cnt <= seq_cnt + 5'h01; // [RULE9]
	end
end

// ****************************************************************
// Output buffer and differential drive
// ****************************************************************
wire [1:0] fifo_out;
wire fifo_out_valid;

// Bit and trigger travel together through the FIFO
prbsg_fifo #(
	.WIDTH(`PRBSG_FIFO_W),
	.DEPTH(`PRBSG_FIFO_D),
	.AW(`PRBSG_FIFO_AW)
) u_fifo (
	.clk(clk),
	.rst_n(rst_n),
	.in_valid(rst_n && !restart),
	.in_ready(fifo_in_ready),
	.in_data({trig_bit, out_bit}),
	.out_valid(fifo_out_valid),
	.out_ready(data_ready),
	.out_data(fifo_out)
);

assign data_valid = fifo_out_valid;

// True and complement in the same cycle
always @(posedge clk)
begin
	if (!rst_n)
	begin
		data_p <= 1'b0;
		data_n <= 1'b1;
		pattern_trigger <= 1'b0;
	end
	else
	begin
		data_p <= fifo_out[0]; // [RULE7]
		data_n <= ~fifo_out[0]; // [RULE7]
		pattern_trigger <= fifo_out_valid && fifo_out[1]; // [RULE6]
	end
end

endmodule

// [rtl/prbsg_defines.vh]
// Constants for the pseudo-random bit sequence generator
// Notes on behaviour
// RULE1 - Three selectable lengths: 2^31-1, 2^15-1, 2^7-1
// RULE2 - Pattern reset restarts sequence from the beginning
// RULE3 - Power-up reset before any sequence output
// RULE4 - Controller resets if short sequence fails start; the code has no such reset
// RULE5 - One sequence bit per full-rate clock
// RULE6 - Trigger pulse marks start of the sequence
// RULE7 - Differential pair: true and complement together
// RULE8 - Polynomials x7+x4, x15+x14, x31+x28 plus one
// RULE9 - Trigger 32 bits wide, every 32 sequences
// RULE10 - Non-zero seed; all-zero state always escaped
`ifndef PRBSG_DEFINES_VH
`define PRBSG_DEFINES_VH

// ****************************************************************
// Length select codes
// ****************************************************************
`define PRBSG_SEL_W 2
`define PRBSG_SEL_P7 2'h0
`define PRBSG_SEL_P15 2'h1
`define PRBSG_SEL_P31 2'h2

// ****************************************************************
// Register and feedback taps
// ****************************************************************
`define PRBSG_LFSR_W 31
`define PRBSG_SEED 31'h7fffffff
`define PRBSG_P7_TAP_A 6
`define PRBSG_P7_TAP_B 3
`define PRBSG_P15_TAP_A 14
`define PRBSG_P15_TAP_B 13
`define PRBSG_P31_TAP_A 30
`define PRBSG_P31_TAP_B 27
`define PRBSG_P7_START 31'h0000007f
`define PRBSG_P15_START 31'h00007fff
`define PRBSG_P31_START 31'h7fffffff

// ****************************************************************
// Trigger timing
// ****************************************************************
`define PRBSG_TRIG_W 6'd32
`define PRBSG_TRIG_SEQS 5'h1f
`define PRBSG_CNT_W 6

// ****************************************************************
// Output FIFO
// ****************************************************************
`define PRBSG_FIFO_W 2
`define PRBSG_FIFO_D 16
`define PRBSG_FIFO_AW 4

`endif

// [rtl/prbsg_fifo.v]
// Synchronous valid/ready FIFO built from flip-flops
`timescale 1ns/100ps
module prbsg_fifo
#(
	parameter WIDTH = 2,
	parameter DEPTH = 16,
	parameter AW = 4
)
(
	input wire clk,
	input wire rst_n,
	input wire in_valid,
	output wire in_ready,
	input wire [WIDTH-1:0] in_data,
	output wire out_valid,
	input wire out_ready,
	output reg [WIDTH-1:0] out_data
);

// ****************************************************************
// Storage and pointers
// ****************************************************************
reg [WIDTH-1:0] mem [0:DEPTH-1];
reg [AW-1:0] wr_ptr;
reg [AW-1:0] rd_ptr;
reg [AW:0] count;
reg out_full;
wire push;
wire pop;
wire fill;
wire [AW-1:0] one_step;

// Handshake terms; output stage is a register ahead of the store
assign one_step = {{(AW-1){1'b0}}, 1'b1};
assign in_ready = (count != DEPTH[AW:0]);
assign out_valid = out_full;
assign fill = (count != {(AW+1){1'b0}}) && (!out_full || out_ready);
assign push = in_valid && in_ready;
assign pop = fill;

// Write side
always @(posedge clk)
begin
	if (!rst_n)
		wr_ptr <= {AW{1'b0}};
	else if (push)
	begin
		mem[wr_ptr] <= in_data;
		wr_ptr <= wr_ptr + one_step;
	end
end

// Read side loads the output register
always @(posedge clk)
begin
	if (!rst_n)
	begin
		rd_ptr <= {AW{1'b0}};
		out_full <= 1'b0;
		out_data <= {WIDTH{1'b0}};
	end
	else
	begin
		if (pop)
		begin
			out_data <= mem[rd_ptr];
			rd_ptr <= rd_ptr + one_step;
			out_full <= 1'b1;
		end
		else if (out_ready)
			out_full <= 1'b0;
	end
end

// Occupancy of the store
always @(posedge clk)
begin
	if (!rst_n)
		count <= {(AW+1){1'b0}};
	else if (push && !pop)
		count <= count + {{AW{1'b0}}, 1'b1};
	else if (pop && !push)
		count <= count - {{AW{1'b0}}, 1'b1};
end

endmodule

// [testbench/prbsg_top_sva.sv]
// Assertions on the generator top ports
`timescale 1ns/100ps
module prbsg_top_sva
(
	input wire clk,
	input wire rst_n,
	input wire pattern_reset_pin,
	input wire [1:0] length_sel_pin,
	input wire data_p,
	input wire data_n,
	input wire pattern_trigger,
	input wire data_valid,
	input wire data_ready
);
reg pq = 1'b0;
reg [5:0] zr = 6'h0;
reg [5:0] tc = 6'h0;
default clocking @(posedge clk); endclocking
default disable iff (!rst_n);
// Pop marker, zero run and trigger width counters
always @(posedge clk)
begin
	pq <= data_valid && data_ready;
	zr <= !pq ? zr : data_p ? 6'h0 : zr + 6'h1;
	tc <= pattern_trigger ? tc + {5'h0, pq} : 6'h0;
end
sequence s_quiet;
	(!pattern_reset_pin && $stable(length_sel_pin))[*5];
endsequence
sequence s_go;
	$fell(pattern_reset_pin) ##0 data_ready[*6];
endsequence
property p_pair; data_n == !data_p; endproperty
a_pair: assert property (p_pair)
	else $error("complement output wrong");
property p_rst; disable iff (1'b0) !rst_n |=> !data_valid && !pattern_trigger;
endproperty
a_rst: assert property (p_rst)
	else $error("outputs active in reset");
property p_boot; $rose(rst_n) |-> !data_valid && !pattern_trigger; endproperty
a_boot: assert property (p_boot)
	else $error("data right after reset");
property p_zero; zr < 6'd31; endproperty
a_zero: assert property (p_zero)
	else $error("zero run too long");
property p_tw; disable iff (!rst_n || pattern_reset_pin)
	$fell(pattern_trigger) |-> tc == 6'd32; endproperty
a_tw: assert property (p_tw)
	else $error("trigger width wrong");
property p_start; $rose(pattern_trigger) |-> data_p[*7]; endproperty
a_start: assert property (p_start)
	else $error("trigger not at start");
property p_flow; s_quiet ##0 data_valid && data_ready |=> data_valid;
endproperty
a_flow: assert property (p_flow)
	else $error("bit stream gap");
property p_go; s_go |-> ##[0:20] $rose(pattern_trigger); endproperty
a_go: assert property (p_go)
	else $error("no restart");
endmodule
bind prbsg_top prbsg_top_sva chk_u (.clk(clk), .rst_n(rst_n),
	.pattern_reset_pin(pattern_reset_pin), .length_sel_pin(length_sel_pin),
	.data_p(data_p), .data_n(data_n), .pattern_trigger(pattern_trigger),
	.data_valid(data_valid), .data_ready(data_ready));

// [testbench/prbsg_sink.sv]
// Consumer model that takes bits from the generator
`timescale 1ns/100ps
module prbsg_sink
(
	input wire clk,
	input wire hold,
	input wire stop,
	input wire rnd,
	output reg data_ready
);
initial data_ready = 1'b0;
// Ready moves after the falling edge; random stalls unless held
always @(negedge clk)
	data_ready <= !stop && (hold || rnd);
endmodule

// [testbench/prbs_pattern_generator_bench.sv]
// Self-checking bench for the generator
`timescale 1ns/100ps
module prbs_pattern_generator_bench;
reg clk = 0, rst_n = 0, prst = 0, hold = 1, stop = 0, rnd = 0, pq = 0;
reg arm = 0, run = 0, t;
reg [1:0] sel = 2'h0;
reg [1:0] e;
reg [30:0] s;
reg [31:0] lf = 32'h6f4ac87f;
reg [1:0] q[$];
wire p, n, trg, vld, rdy;
integer fail_count = 0, samples_checked = 0, i, k, w;
prbsg_top dut_u (.clk(clk), .rst_n(rst_n), .pattern_reset_pin(prst),
	.length_sel_pin(sel), .data_p(p), .data_n(n), .pattern_trigger(trg),
	.data_valid(vld), .data_ready(rdy));
prbsg_sink sink_u (.clk(clk), .hold(hold), .stop(stop), .rnd(rnd),
	.data_ready(rdy));
function [31:0] nx(input [31:0] v);
	nx = {v[30:0], v[31] ^ v[21] ^ v[1] ^ v[0]};
endfunction
task chk(input [1:0] x, input [1:0] g);
begin
	samples_checked = samples_checked + 1;
	if (g !== x)
	begin
		fail_count = fail_count + 1;
		$display("CHECK FAILED t=%0t exp %h got %h", $time, x, g);
	end
end
endtask
task test_done;
begin
	$display("mismatches %0d checks %0d", fail_count, samples_checked);
	if (fail_count == 0 && samples_checked > 0)
		$display("DONE - PASS");
	else
		$display("DONE - FAIL");
	$finish;
end
endtask
initial
	forever #25 clk = ~clk;
// Random stall pattern for the consumer
always @(negedge clk)
begin
	lf = nx(lf);
	rnd <= lf[0];
end
// Watch pops and compare against the oldest note
always @(posedge clk)
	pq <= vld && rdy;
always @(negedge clk)
begin
	if (pq && arm && trg)
		run = 1'b1;
	if (pq && run && q.size() > 0)
	begin
		e = q.pop_front();
		chk(e, {trg, p});
		chk({1'b0, ~p}, {1'b0, n});
	end
end
initial
begin
	#4000000;
	fail_count = fail_count + 1;
	test_done;
end
// Each length: restart, random stalls, a long stall, then drain
initial
begin
	repeat (16) @(negedge clk);
	rst_n = 1'b1;
	for (k = 0; k < 4; k = k + 1)
	begin
		hold = 1'b1;
		sel = k[1:0];
		prst = 1'b1;
		repeat (30) @(negedge clk);
		w = (k == 0) ? 7 : (k == 1) ? 15 : 31;
		s = 31'h7fffffff;
		for (i = 0; i < 4200; i = i + 1)
		begin
			t = (w == 7) ? (i % 4064) < 32 : i < 32;
			q.push_back({t, s[w-1]});
			s = {s[29:0], s[w-1] ^ s[(w == 15) ? 13 : w-4]};
		end
		arm = 1'b1;
		prst = 1'b0;
		repeat (40) @(negedge clk);
		hold = 1'b0;
		repeat (300) @(negedge clk);
		stop = 1'b1;
		repeat (40) @(negedge clk);
		stop = 1'b0;
		i = 0;
		while (q.size() > 0 && i < 20000)
		begin
			@(negedge clk);
			i = i + 1;
		end
		chk(2'h0, {1'b0, q.size() > 0});
		q.delete();
		arm = 1'b0;
		run = 1'b0;
	end
	test_done;
end
endmodule
